// >>> hw/mcrt_pkg.sv
package mcrt_pkg;

    // Register byte offsets, each base register followed by its set, clear and invert aliases
    localparam logic [5:0] MCRT_CLRT_OFS = 6'h00;
    localparam logic [5:0] MCRT_TEST_OFS = 6'h10;
    localparam logic [5:0] MCRT_STAT_OFS = 6'h20;
    localparam logic [1:0] MCRT_ALIAS_PLAIN = 2'h0;
    localparam logic [1:0] MCRT_ALIAS_SET = 2'h1;
    localparam logic [1:0] MCRT_ALIAS_CLR = 2'h2;
    localparam logic [1:0] MCRT_ALIAS_INV = 2'h3;

    // Field positions
    localparam int MCRT_RETRY_ATTEMPT_LIMIT_LSB = 0;
    localparam int MCRT_CWIN_LSB = 8;
    localparam int MCRT_SHRTQ_BIT = 0;
    localparam int MCRT_TPAUSE_BIT = 1;
    localparam int MCRT_TBP_BIT = 2;

    // Reset values
    localparam logic [5:0] MCRT_CWIN_RST = 6'h37;
    localparam logic [3:0] MCRT_RETRY_ATTEMPT_LIMIT_RST = 4'hF;
    localparam logic [2:0] MCRT_TEST_RST = 3'h0;

    // Pause quantum lengths in byte times
    localparam logic [6:0] MCRT_QUANTUM_NORMAL = 7'h40;
    localparam logic [6:0] MCRT_QUANTUM_SHORT = 7'h01;

    // Transmit sequencer states
    typedef enum logic [2:0] {
        MCRT_IDLE,
        MCRT_SEND,
        MCRT_BACKOFF,
        MCRT_DONE_OK,
        MCRT_DONE_ABORT,
        MCRT_DONE_LATE
    } mcrt_state_t;

    // Result of one packet, registered toward the MAC
    typedef struct packed {
        logic done;
        logic excess_col;
        logic late_col;
        logic [3:0] attempts;
    } mcrt_result_t;

endpackage

// >>> hw/mcrt_pause_timer.sv
`timescale 1ns/1ps
module mcrt_pause_timer
    import mcrt_pkg::*;
#(
    parameter int QW = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic load_i,
    input wire logic [QW-1:0] quanta_i,
    input wire logic short_q_i,
    input wire logic byte_tick_i,
    // Status
    output logic active_o
);
    // Elaboration check on the quanta counter width
    if (QW < 1 || QW > 24) begin : g_bad_qw
        $error("mcrt_pause_timer: QW out of range");
    end

    logic [QW-1:0] quanta_r, quanta_nxt;
    logic [6:0] bytes_r, bytes_nxt;
    logic [6:0] qlen;

    // Next value of quantum and byte-time counters
    always_comb begin
        qlen = short_q_i ? MCRT_QUANTUM_SHORT : MCRT_QUANTUM_NORMAL;
        quanta_nxt = quanta_r;
        bytes_nxt = bytes_r;
        if (load_i) begin
            quanta_nxt = quanta_i;
            bytes_nxt = 7'h00;
        end else if (byte_tick_i && quanta_r != '0) begin
            if (bytes_r + 7'h01 >= qlen) begin
                bytes_nxt = 7'h00;
                quanta_nxt = quanta_r - 1'b1;
            end else begin
                bytes_nxt = bytes_r + 7'h01;
            end
        end
    end

    // Counter registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            quanta_r <= '0;
            bytes_r <= 7'h00;
            active_o <= 1'b0;
        end else begin
            quanta_r <= quanta_nxt;
            bytes_r <= bytes_nxt;
            active_o <= (quanta_nxt != '0);
        end
    end
endmodule

// >>> hw/mcrt_top.sv
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module mcrt_top
    import mcrt_pkg::*;
#(
    parameter int QW = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Transmit path from the MAC
    input wire logic tx_req_i,
    input wire logic byte_tick_i,
    input wire logic tx_end_i,
    input wire logic collision_i,
    input wire logic backoff_done_i,
    input wire logic pause_load_i,
    input wire logic [QW-1:0] pause_quanta_i,
    // Toward the medium and MAC
    output logic tx_active_o,
    output logic preamble_o,
    output logic tx_hold_o,
    output logic backoff_start_o,
    output mcrt_result_t result_o
);
    // Elaboration check on the pause counter width
    if (QW < 1 || QW > 24) begin : g_bad_qw
        $error("mcrt_top: QW out of range");
    end

    logic [5:0] cwin_r, cwin_nxt;
    logic [3:0] retry_attempt_limit_r, retry_attempt_limit_nxt;
    logic [2:0] test_r, test_nxt;
    logic [31:0] dat_nxt;
    logic ack_nxt;
    logic [31:0] clrt_val, test_val, stat_val, cur_val, wr_val;
    logic wide_ok, acc;

    mcrt_state_t state_r, state_nxt;
    logic [5:0] bytes_r, bytes_nxt;
    logic [3:0] att_r, att_nxt;
    logic hold_nxt, pre_nxt, act_nxt, bo_nxt;
    mcrt_result_t res_nxt;
    logic pause_active;
    logic tx_hold_int;

    assign clrt_val = {18'h0, cwin_r, 4'h0, retry_attempt_limit_r};
    assign test_val = {29'h0, test_r};
    assign stat_val = {24'h0, 1'b0, state_r, att_r};

    assign wide_ok = (wb_sel_i == 4'hF) || (wb_sel_i == 4'h3) || (wb_sel_i == 4'hC);
    assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Register file next state and bus answer
    always_comb begin
        cwin_nxt = cwin_r;
        retry_attempt_limit_nxt = retry_attempt_limit_r;
        test_nxt = test_r;
        ack_nxt = 1'b0;
        dat_nxt = wb_dat_o;
        cur_val = 32'h0;
        wr_val = 32'h0;
        case (wb_adr_i[5:4])
            MCRT_CLRT_OFS[5:4]: cur_val = clrt_val;
            MCRT_TEST_OFS[5:4]: cur_val = test_val;
            MCRT_STAT_OFS[5:4]: cur_val = stat_val;
            default: cur_val = 32'h0;
        endcase
        for (int i = 0; i < 4; i++) begin
            wr_val[i*8 +: 8] = wb_sel_i[i] ? wb_dat_i[i*8 +: 8] : 8'h00;
        end
        case (wb_adr_i[3:2])
            MCRT_ALIAS_SET: wr_val = cur_val | wr_val;
            MCRT_ALIAS_CLR: wr_val = cur_val & ~wr_val;
            MCRT_ALIAS_INV: wr_val = cur_val ^ wr_val;
            default: begin
                for (int i = 0; i < 4; i++) begin
                    if (!wb_sel_i[i]) begin
                        wr_val[i*8 +: 8] = cur_val[i*8 +: 8];
                    end
                end
            end
        endcase
        if (acc) begin
            ack_nxt = 1'b1;
            dat_nxt = 32'h0;
            if (!wb_we_i) begin
                dat_nxt = wide_ok ? cur_val : 32'h0;
            end else if (wide_ok) begin
                if (wb_adr_i[5:4] == MCRT_CLRT_OFS[5:4]) begin
                    cwin_nxt = wr_val[MCRT_CWIN_LSB +: 6];
                    retry_attempt_limit_nxt = wr_val[MCRT_RETRY_ATTEMPT_LIMIT_LSB +: 4];
                end else if (wb_adr_i[5:4] == MCRT_TEST_OFS[5:4]) begin
                    test_nxt = wr_val[2:0];
                end
            end
        end
    end

    // Register file state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cwin_r <= MCRT_CWIN_RST;
            retry_attempt_limit_r <= MCRT_RETRY_ATTEMPT_LIMIT_RST;
            test_r <= MCRT_TEST_RST;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            cwin_r <= cwin_nxt;
            retry_attempt_limit_r <= retry_attempt_limit_nxt;
            test_r <= test_nxt;
            wb_ack_o <= ack_nxt;
            wb_dat_o <= dat_nxt;
        end
    end

    mcrt_pause_timer #(
        .QW(QW)
    ) u_pause (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(pause_load_i),
        .quanta_i(pause_quanta_i),
        .short_q_i(test_r[MCRT_SHRTQ_BIT]),
        .byte_tick_i(byte_tick_i),
        .active_o(pause_active)
    );

    // test bit acts as received pause
    assign tx_hold_int = pause_active || test_r[MCRT_TPAUSE_BIT];

    // Transmit sequencer next state
    always_comb begin
        state_nxt = state_r;
        bytes_nxt = bytes_r;
        att_nxt = att_r;
        bo_nxt = 1'b0;
        res_nxt = '0;
        case (state_r)
            MCRT_IDLE: begin
                if (tx_req_i && !tx_hold_int) begin
                    state_nxt = MCRT_SEND;
                    bytes_nxt = 6'h00;
                    att_nxt = 4'h0;
                end
            end
            MCRT_SEND: begin
                // count from the first preamble byte
                if (byte_tick_i && bytes_r != 6'h3F) begin
                    bytes_nxt = bytes_r + 6'h01;
                end
                if (collision_i) begin
                    if (bytes_r >= cwin_r) begin
                        state_nxt = MCRT_DONE_LATE;
                    end else if (att_r >= retry_attempt_limit_r) begin
                        state_nxt = MCRT_DONE_ABORT;
                    end else begin
                        state_nxt = MCRT_BACKOFF;
                        att_nxt = att_r + 4'h1;
                        bo_nxt = 1'b1;
                    end
                end else if (tx_end_i) begin
                    state_nxt = MCRT_DONE_OK;
                end
            end
            MCRT_BACKOFF: begin
                if (backoff_done_i && !tx_hold_int) begin
                    state_nxt = MCRT_SEND;
                    bytes_nxt = 6'h00;
                end
            end
            MCRT_DONE_OK, MCRT_DONE_ABORT, MCRT_DONE_LATE: begin
                res_nxt.done = 1'b1;
                res_nxt.excess_col = (state_r == MCRT_DONE_ABORT);
                res_nxt.late_col = (state_r == MCRT_DONE_LATE);
                res_nxt.attempts = att_r;
                state_nxt = MCRT_IDLE;
            end
            default: state_nxt = MCRT_IDLE;
        endcase
        act_nxt = (state_nxt == MCRT_SEND);
        // backpressure raises carrier, packets still go out
        pre_nxt = test_r[MCRT_TBP_BIT] && !act_nxt;
        hold_nxt = tx_hold_int;
    end

    // Transmit sequencer state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= MCRT_IDLE;
            bytes_r <= 6'h00;
            att_r <= 4'h0;
            tx_active_o <= 1'b0;
            preamble_o <= 1'b0;
            tx_hold_o <= 1'b0;
            backoff_start_o <= 1'b0;
            result_o <= '0;
        end else begin
            state_r <= state_nxt;
            bytes_r <= bytes_nxt;
            att_r <= att_nxt;
            tx_active_o <= act_nxt;
            preamble_o <= pre_nxt;
            tx_hold_o <= hold_nxt;
            backoff_start_o <= bo_nxt;
            result_o <= res_nxt;
        end
    end
endmodule

// >>> testbench/mcrt_phy_model.sv
`timescale 1ns/1ps
module mcrt_phy_model (
    // Clock
    input wire logic clk_i,
    // From the block
    input wire logic active_i,
    input wire logic bo_i,
    // Scenario control
    input wire logic slow_i,
    input wire logic [5:0] col_i,
    input wire logic [5:0] len_i,
    // Toward the block
    output logic byte_tick_o,
    output logic tx_end_o = 1'b0,
    output logic collision_o = 1'b0,
    output logic backoff_done_o
);
    logic ph = 1'b0;
    logic [5:0] cnt = 6'h00;
    logic [2:0] bd = 3'h0;
    // Byte times every cycle, or every second cycle when slow
    assign byte_tick_o = !slow_i || ph;
    assign backoff_done_o = bd[2];
    // Bytes counted from attempt start; collision or end at a set count
    always @(posedge clk_i) begin
        ph <= !ph;
        bd <= {bd[1:0], bo_i};
        cnt <= active_i ? cnt + {5'h00, byte_tick_o} : 6'h00;
        collision_o <= active_i && byte_tick_o && col_i != 6'h00 && cnt + 6'h01 == col_i;
        tx_end_o <= active_i && byte_tick_o && len_i != 6'h00 && cnt + 6'h01 == len_i;
    end
endmodule

// >>> testbench/mcrt_top_properties.sv
`timescale 1ns/1ps
module mcrt_top_properties
    import mcrt_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Transmit
    input wire logic tx_active_o,
    input wire logic preamble_o,
    input wire logic backoff_start_o,
    input wire mcrt_result_t result_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Request taken, and reads that must return zero
    logic take;
    logic zero_rd;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign zero_rd = !wb_we_i && (wb_adr_i[5:4] == 2'h3 ||
        !(wb_sel_i == 4'hF || wb_sel_i == 4'h3 || wb_sel_i == 4'hC));
    // Bus, pulse and transmit relations
    ack_resp_a: assert property (take |=> wb_ack_o)
        else $error("no ack after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    zero_read_a: assert property (take && zero_rd |=> wb_dat_o == 32'h0)
        else $error("ignored read not zero");
    done_pulse_a: assert property (result_o.done |=> !result_o.done)
        else $error("result longer than one cycle");
    retry_pulse_a: assert property (backoff_start_o |=> !backoff_start_o)
        else $error("backoff pulse too long");
    flags_excl_a: assert property (result_o.done |-> !(result_o.excess_col && result_o.late_col))
        else $error("late and excess together");
    pre_idle_a: assert property (preamble_o |-> !tx_active_o)
        else $error("preamble while sending");
    rst_quiet_a: assert property ($fell(rst_i) |-> !tx_active_o && !wb_ack_o && !result_o.done)
        else $error("outputs active after reset");
endmodule

bind mcrt_top mcrt_top_properties i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_active_o(tx_active_o),
    .preamble_o(preamble_o), .backoff_start_o(backoff_start_o), .result_o(result_o));

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import mcrt_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, tx_req, pload, slow, ack, act, pre, hold, bo, tick, fin, col_s, bd;
    logic [5:0] adr, col, len;
    logic [3:0] sel, lim;
    logic [31:0] dat, rdat;
    logic [15:0] quanta;
    mcrt_result_t res;
    mcrt_result_t res_q[$];
    logic [31:0] rd_q[$];
    int num_errors = 0;
    int n_compared = 0;
    int n_bo = 0;
    mcrt_top #(.QW(16)) i_mcrt_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .tx_req_i(tx_req), .byte_tick_i(tick),
        .tx_end_i(fin), .collision_i(col_s), .backoff_done_i(bd), .pause_load_i(pload),
        .pause_quanta_i(quanta), .tx_active_o(act), .preamble_o(pre), .tx_hold_o(hold),
        .backoff_start_o(bo), .result_o(res));
    mcrt_phy_model i_mcrt_phy_model (.clk_i(clk_i), .active_i(act), .bo_i(bo),
        .slow_i(slow), .col_i(col), .len_i(len), .byte_tick_o(tick), .tx_end_o(fin),
        .collision_o(col_s), .backoff_done_o(bd));
    // Clock generation
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // One classic cycle, released after the edge that samples ack high
    task automatic bus(logic w, logic [5:0] a, logic [3:0] s, logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rd(logic [5:0] a, logic [3:0] s, logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, s, 32'h0);
    endtask
    task automatic start(logic [5:0] c, logic [5:0] l, mcrt_result_t e);
        res_q.push_back(e);
        @(posedge clk_i);
        {col, len, tx_req} <= {c, l, 1'b1};
    endtask
    task automatic finish_pkt;
        do @(negedge clk_i); while (act !== 1'b1);
        @(posedge clk_i);
        tx_req <= 1'b0;
        while (res_q.size() != 0) @(negedge clk_i);
        $display("packet test done");
    endtask
    // Monitor compares reads and results against the oldest note
    always @(negedge clk_i) begin
        if (ack === 1'b1 && !we)
            check("read data", rdat, rd_q.pop_front());
        if (res.done === 1'b1)
            check("result", 32'(res), 32'(res_q.pop_front()));
        if (bo === 1'b1)
            n_bo++;
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        $display("watchdog expired");
        wrap_up();
    end
    // Main sequence
    initial begin
        {rst_i, cyc, stb, we, tx_req, pload, slow, adr, col, len, sel, dat, quanta} = '0;
        rst_i = 1'b1;
        void'($urandom(56116));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(6'h00, 4'hF, 32'h370F);
        rd(6'h10, 4'hF, 32'h0);
        rd(6'h30, 4'hF, 32'h0);
        bus(1'b1, 6'h00, 4'h1, 32'h0);
        rd(6'h00, 4'hF, 32'h370F);
        bus(1'b1, 6'h00, 4'h3, 32'h0402);
        rd(6'h00, 4'hC, 32'h0402);
        rd(6'h00, 4'h1, 32'h0);
        rd(6'h00, 4'h3, 32'h0402);
        bus(1'b1, 6'h04, 4'hF, 32'h1);
        bus(1'b1, 6'h08, 4'hF, 32'h2);
        bus(1'b1, 6'h0C, 4'hF, 32'h0100);
        rd(6'h00, 4'hF, 32'h0501);
        $display("register test done");
        for (int i = 0; i < 3; i++) begin
            slow <= i[0];
            lim = (i == 2) ? 4'h0 : 4'($urandom_range(3, 1));
            bus(1'b1, 6'h00, 4'hF, {18'h0, 6'h05, 4'h0, lim});
            start(6'h00, 6'h08, 7'h40);
            finish_pkt();
            n_bo = 0;
            start(6'h02, 6'h00, {3'b110, lim});
            finish_pkt();
            check("retries", 32'(n_bo), 32'(lim));
            start(6'h14, 6'h00, 7'h50);
            finish_pkt();
        end
        bus(1'b1, 6'h14, 4'hF, 32'h2);
        start(6'h00, 6'h08, 7'h40);
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        check("held", 32'(act), 32'h0);
        check("hold", 32'(hold), 32'h1);
        bus(1'b1, 6'h18, 4'hF, 32'h2);
        finish_pkt();
        bus(1'b1, 6'h14, 4'hF, 32'h4);
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        check("preamble", 32'(pre), 32'h1);
        start(6'h00, 6'h08, 7'h40);
        finish_pkt();
        bus(1'b1, 6'h18, 4'hF, 32'h4);
        slow <= 1'b0;
        for (int q = 0; q < 2; q++) begin
            bus(1'b1, q ? 6'h18 : 6'h14, 4'hF, 32'h1);
            rd(6'h10, 4'hF, 32'(q == 0));
            quanta <= 16'h0003;
            pload <= 1'b1;
            @(posedge clk_i);
            pload <= 1'b0;
            repeat (20) @(posedge clk_i);
            @(negedge clk_i);
            check("pause", 32'(hold), 32'(q));
            repeat (60) @(posedge clk_i);
        end
        $display("pause test done");
        wrap_up();
    end
endmodule
